// ===== shared/lock_ctl_consts.svh
// command codes, addresses and bus timing for the lock overlay host
// assumes a x16 flash with 26 word-address bits and a 100 MHz mclk_i
`ifndef LOCK_CTL_CONSTS_SVH
`define LOCK_CTL_CONSTS_SVH

// ****************************************************************
// command words
// ****************************************************************
`define CMD_RESET       16'h00F0
`define CMD_SR_ENTER    16'h0070
`define CMD_SR_CLEAR    16'h0071
`define CMD_PROG_ENTRY  16'h00A0
`define CMD_ERASE_ENTER 16'h0080
`define CMD_ERASE_START 16'h0030
`define CMD_EXIT_ENTRY  16'h0090
`define CMD_EXIT        16'h0000
`define CMD_LOCK_SET    16'h0000
`define CMD_LOCK_CLEAR  16'h0001

// ****************************************************************
// addresses and bit positions
// ****************************************************************
`define ADDR_W          26
`define UNLOCK_ADDR     26'h0000555
`define ZERO_ADDR       26'h0000000
`define SR_READY_BIT    7
`define LR_FREEZE_BIT_A 2
`define LR_FREEZE_BIT_B 5

// ****************************************************************
// bus timing
// ****************************************************************
`define CLK_PERIOD_NS   10
`define STROBE_NS       100
`define RECOVER_NS      30
`define STROBE_CYC      ((`STROBE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RECOVER_CYC     ((`RECOVER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ===== shared/lock_ctl_pkg.sv
// types shared by the lock overlay host modules
// assumes nothing beyond a SystemVerilog compiler
package lock_ctl_pkg;

  typedef enum logic [3:0] {
    ARRAY_READ                   = 4'h0,
    NONVOLATILE_SECTOR_LOCK_MODE = 4'h1,
    NV_LOCK_REQUEST_STATE        = 4'h2,
    NV_LOCK_PROGRAM_BUSY         = 4'h3,
    NV_LOCK_ERASE_BUSY           = 4'h4,
    NV_LOCK_EXIT_PENDING         = 4'h5,
    LOCK_FREEZE_MODE             = 4'h6,
    FREEZE_SET_STATE             = 4'h7,
    FREEZE_EXIT_PENDING          = 4'h8,
    VOLATILE_SECTOR_LOCK_MODE    = 4'h9,
    VOLATILE_SET_CLEAR_STATE     = 4'hA,
    VOLATILE_EXIT_PENDING        = 4'hB,
    STATUS_READ_STATE            = 4'hC
  } dev_state_t;

  typedef enum logic [2:0] {
    OP_NV_PROGRAM = 3'h0,
    OP_NV_ERASE   = 3'h1,
    OP_FREEZE     = 3'h2,
    OP_VOL_SET    = 3'h3,
    OP_VOL_CLEAR  = 3'h4,
    OP_STATUS     = 3'h5,
    OP_EXIT       = 3'h6,
    OP_ABORT      = 3'h7
  } host_op_t;

  typedef enum logic [1:0] {
    ENTER_NV       = 2'h0,
    ENTER_FREEZE   = 2'h1,
    ENTER_VOLATILE = 2'h2
  } mode_sel_t;

  typedef enum logic [1:0] {
    E_IDLE    = 2'h0,
    E_STROBE  = 2'h1,
    E_RECOVER = 2'h2
  } eng_state_t;

  typedef enum logic [2:0] {
    M_IDLE     = 3'h0,
    M_SEQ      = 3'h1,
    M_POLL_ENT = 3'h2,
    M_POLL_RD  = 3'h3,
    M_CLEAR    = 3'h4,
    M_STAT_RD  = 3'h5
  } main_state_t;

endpackage

// ===== hdl/flash_cycle_engine.sv
// one asynchronous flash bus cycle per request, write or read
// assumes dq_i settles within the strobe time and is synchronous here
`include "lock_ctl_consts.svh"

module flash_cycle_engine (
  // clock and reset
  input  wire logic                     mclk_i,
  input  wire logic                     rstn_i,
  // cycle request
  input  wire logic                     req_i,
  input  wire logic                     req_write_i,
  input  wire logic [`ADDR_W-1:0]       req_addr_i,
  input  wire logic [15:0]              req_data_i,
  output      logic                     idle_o,
  output      logic                     done_o,
  output      logic [15:0]              rdata_o,
  // flash pins
  output      logic [`ADDR_W-1:0]       flash_addr_o,
  output      logic [15:0]              dq_o,
  output      logic                     dq_oe_o,
  input  wire logic [15:0]              dq_i,
  output      logic                     ce_n_o,
  output      logic                     we_n_o,
  output      logic                     oe_n_o
);
  import lock_ctl_pkg::*;

  eng_state_t st_q;
  logic [3:0] cnt_q;
  logic       wr_q;

  assign idle_o = (st_q == E_IDLE);

  // ****************************************************************
  // strobe then recovery; address held through both
  // ****************************************************************
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_q         <= E_IDLE;
      cnt_q        <= 4'h0;
      wr_q         <= 1'b0;
      done_o       <= 1'b0;
      rdata_o      <= 16'h0000;
      flash_addr_o <= '0;
      dq_o         <= 16'h0000;
      dq_oe_o      <= 1'b0;
      ce_n_o       <= 1'b1;
      we_n_o       <= 1'b1;
      oe_n_o       <= 1'b1;
    end else begin
      done_o <= 1'b0;
      unique case (st_q)
        E_IDLE: begin
          if (req_i) begin
            st_q         <= E_STROBE;
            cnt_q        <= 4'(`STROBE_CYC - 1);
            wr_q         <= req_write_i;
            flash_addr_o <= req_addr_i;
            dq_o         <= req_data_i;
            dq_oe_o      <= req_write_i;
            ce_n_o       <= 1'b0;
            we_n_o       <= !req_write_i;
            oe_n_o       <= req_write_i;
          end
        end
        E_STROBE: begin
          if (cnt_q == 4'h0) begin
            if (!wr_q) begin
              rdata_o <= dq_i;
            end
            st_q   <= E_RECOVER;
            cnt_q  <= 4'(`RECOVER_CYC - 1);
            ce_n_o <= 1'b1;
            we_n_o <= 1'b1;
            oe_n_o <= 1'b1;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        E_RECOVER: begin
          if (cnt_q == 4'h0) begin
            // data released only after the recovery, so no bus fight
            dq_oe_o <= 1'b0;
            done_o  <= 1'b1;
            st_q    <= E_IDLE;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        default: st_q <= E_IDLE;
      endcase
    end
  end

endmodule

// ===== hdl/cmd_word_select.sv
// address and data of each write step of a host operation
// assumes step 1 is only used when two_step_o is high
`include "lock_ctl_consts.svh"

module cmd_word_select (
  // selection
  input  wire lock_ctl_pkg::host_op_t   op_i,
  input  wire logic                     step_i,
  input  wire logic [`ADDR_W-1:0]       sector_addr_i,
  // chosen write
  output      logic [`ADDR_W-1:0]       addr_o,
  output      logic [15:0]              data_o,
  output      logic                     two_step_o
);
  import lock_ctl_pkg::*;

  always_comb begin
    addr_o     = `ZERO_ADDR;
    data_o     = `CMD_RESET;
    two_step_o = 1'b1;
    unique case (op_i)
      OP_NV_PROGRAM: begin
        data_o = step_i ? `CMD_LOCK_SET : `CMD_PROG_ENTRY;
        addr_o = step_i ? sector_addr_i : `ZERO_ADDR;
      end
      OP_NV_ERASE: begin
        data_o = step_i ? `CMD_ERASE_START : `CMD_ERASE_ENTER;
      end
      OP_FREEZE: begin
        data_o = step_i ? `CMD_LOCK_SET : `CMD_PROG_ENTRY;
      end
      OP_VOL_SET: begin
        data_o = step_i ? `CMD_LOCK_SET : `CMD_PROG_ENTRY;
        addr_o = step_i ? sector_addr_i : `ZERO_ADDR;
      end
      OP_VOL_CLEAR: begin
        data_o = step_i ? `CMD_LOCK_CLEAR : `CMD_PROG_ENTRY;
        addr_o = step_i ? sector_addr_i : `ZERO_ADDR;
      end
      OP_STATUS: begin
        data_o     = `CMD_SR_ENTER;
        addr_o     = `UNLOCK_ADDR;
        two_step_o = 1'b0;
      end
      OP_EXIT: begin
        data_o = step_i ? `CMD_EXIT : `CMD_EXIT_ENTRY;
      end
      OP_ABORT: begin
        two_step_o = 1'b0;
      end
    endcase
  end

endmodule

// ===== hdl/lock_overlay_host.sv
// host controller driving the sector lock overlay command sequences
// assumes the overlay mode was entered elsewhere and reported by mode_enter_i
`include "lock_ctl_consts.svh"

module lock_overlay_host (
  // clock and reset
  input  wire logic                     mclk_i,
  input  wire logic                     rstn_i,
  // mode entry report from the outer sequencer
  input  wire logic                     mode_enter_i,
  input  wire lock_ctl_pkg::mode_sel_t  mode_sel_i,
  input  wire logic [15:0]              lock_config_i,
  // operation request
  input  wire logic                     start_i,
  input  wire lock_ctl_pkg::host_op_t   op_i,
  input  wire logic [`ADDR_W-1:0]       sector_addr_i,
  output      logic                     ready_o,
  output      logic                     done_o,
  output      logic                     err_o,
  output      logic [15:0]              status_o,
  output      lock_ctl_pkg::dev_state_t dev_state_o,
  // flash pins
  output      logic [`ADDR_W-1:0]       flash_addr_o,
  output      logic [15:0]              dq_o,
  output      logic                     dq_oe_o,
  input  wire logic [15:0]              dq_i,
  output      logic                     ce_n_o,
  output      logic                     we_n_o,
  output      logic                     oe_n_o
);
  import lock_ctl_pkg::*;

  // ****************************************************************
  // legality of an operation against the tracked device state
  // ****************************************************************
  function automatic logic op_legal(input host_op_t op, input dev_state_t st,
                                    input logic [15:0] lr);
    logic in_mode;
    in_mode = (st == NONVOLATILE_SECTOR_LOCK_MODE) || (st == LOCK_FREEZE_MODE) ||
              (st == VOLATILE_SECTOR_LOCK_MODE);
    unique case (op)
      OP_NV_PROGRAM, OP_NV_ERASE: op_legal = (st == NONVOLATILE_SECTOR_LOCK_MODE);
      OP_FREEZE:     op_legal = (st == LOCK_FREEZE_MODE) &&
                                !lr[`LR_FREEZE_BIT_A] && !lr[`LR_FREEZE_BIT_B];
      OP_VOL_SET, OP_VOL_CLEAR: op_legal = (st == VOLATILE_SECTOR_LOCK_MODE);
      OP_ABORT:      op_legal = in_mode || (st == NV_LOCK_REQUEST_STATE);
      default:       op_legal = in_mode;
    endcase
  endfunction

  main_state_t       st_q;
  main_state_t       st_d;
  host_op_t          op_q;
  logic              step_q;
  logic              issued_q;
  logic [`ADDR_W-1:0] sa_q;
  dev_state_t        dev_q;
  dev_state_t        dev_d;
  dev_state_t        ret_q;
  dev_state_t        ret_d;
  logic [15:0]       lr_q;
  logic [15:0]       status_q;
  logic              done_q;
  logic              err_q;

  // engine and selector wires
  logic              eng_idle;
  logic              eng_done;
  logic [15:0]       eng_rdata;
  logic [`ADDR_W-1:0] sel_addr;
  logic [15:0]       sel_data;
  logic              two_step;
  logic              cur_write;
  logic [`ADDR_W-1:0] cur_addr;
  logic [15:0]       cur_data;
  logic              eng_req;
  logic              sr_ready;
  logic              start_ok;
  logic              seq_last;
  logic              is_unlock;

  assign ready_o     = (st_q == M_IDLE);
  assign done_o      = done_q;
  assign err_o       = err_q;
  assign status_o    = status_q;
  assign dev_state_o = dev_q;
  assign start_ok    = start_i && ready_o && op_legal(op_i, dev_q, lock_config_i);
  assign sr_ready    = eng_rdata[`SR_READY_BIT];
  assign seq_last    = step_q || !two_step;
  assign eng_req     = (st_q != M_IDLE) && !issued_q && eng_idle;
  assign is_unlock   = (cur_addr == `UNLOCK_ADDR);

  // ****************************************************************
  // cycle chosen for the current step
  // ****************************************************************
  assign cur_write = (st_q == M_SEQ) || (st_q == M_POLL_ENT) || (st_q == M_CLEAR);
  assign cur_addr  = (st_q == M_SEQ) ? sel_addr :
                     (cur_write ? `UNLOCK_ADDR : `ZERO_ADDR);
  assign cur_data  = (st_q == M_SEQ)     ? sel_data :
                     (st_q == M_CLEAR)   ? `CMD_SR_CLEAR : `CMD_SR_ENTER;

  cmd_word_select u_sel (
    .op_i          (op_q),
    .step_i        (step_q),
    .sector_addr_i (sa_q),
    .addr_o        (sel_addr),
    .data_o        (sel_data),
    .two_step_o    (two_step)
  );

  flash_cycle_engine u_eng (
    .mclk_i       (mclk_i),
    .rstn_i       (rstn_i),
    .req_i        (eng_req),
    .req_write_i  (cur_write),
    .req_addr_i   (cur_addr),
    .req_data_i   (cur_data),
    .idle_o       (eng_idle),
    .done_o       (eng_done),
    .rdata_o      (eng_rdata),
    .flash_addr_o (flash_addr_o),
    .dq_o         (dq_o),
    .dq_oe_o      (dq_oe_o),
    .dq_i         (dq_i),
    .ce_n_o       (ce_n_o),
    .we_n_o       (we_n_o),
    .oe_n_o       (oe_n_o)
  );

  // ****************************************************************
  // device state mirror, advanced by each finished cycle
  // ****************************************************************
  always_comb begin
    dev_d = dev_q;
    ret_d = ret_q;
    if (mode_enter_i && ready_o) begin
      unique case (mode_sel_i)
        ENTER_NV:       dev_d = NONVOLATILE_SECTOR_LOCK_MODE;
        ENTER_FREEZE:   dev_d = LOCK_FREEZE_MODE;
        ENTER_VOLATILE: dev_d = VOLATILE_SECTOR_LOCK_MODE;
        default:        dev_d = dev_q;
      endcase
    end else if (eng_done && !cur_write) begin
      if (dev_q == STATUS_READ_STATE) begin
        dev_d = ret_q;
      end
    end else if (eng_done) begin
      unique case (dev_q)
        NONVOLATILE_SECTOR_LOCK_MODE, LOCK_FREEZE_MODE, VOLATILE_SECTOR_LOCK_MODE: begin
          if (cur_data == `CMD_RESET) begin
            dev_d = ARRAY_READ;
          end else if (cur_data == `CMD_SR_ENTER && is_unlock) begin
            dev_d = STATUS_READ_STATE;
            ret_d = dev_q;
          end else if (cur_data == `CMD_EXIT_ENTRY) begin
            dev_d = (dev_q == LOCK_FREEZE_MODE) ? FREEZE_EXIT_PENDING :
                    (dev_q == VOLATILE_SECTOR_LOCK_MODE) ? VOLATILE_EXIT_PENDING :
                    NV_LOCK_EXIT_PENDING;
          end else if (cur_data == `CMD_PROG_ENTRY) begin
            dev_d = (dev_q == LOCK_FREEZE_MODE) ? FREEZE_SET_STATE :
                    (dev_q == VOLATILE_SECTOR_LOCK_MODE) ? VOLATILE_SET_CLEAR_STATE :
                    NV_LOCK_REQUEST_STATE;
          end else if (cur_data == `CMD_ERASE_ENTER &&
                       dev_q == NONVOLATILE_SECTOR_LOCK_MODE) begin
            dev_d = NV_LOCK_REQUEST_STATE;
          end
        end
        NV_LOCK_REQUEST_STATE: begin
          if (cur_data == `CMD_RESET) begin
            dev_d = ARRAY_READ;
          end else if (cur_data == `CMD_LOCK_SET) begin
            dev_d = NV_LOCK_PROGRAM_BUSY;
          end else if (cur_data == `CMD_ERASE_START && cur_addr == `ZERO_ADDR) begin
            dev_d = NV_LOCK_ERASE_BUSY;
          end
        end
        NV_LOCK_PROGRAM_BUSY, NV_LOCK_ERASE_BUSY: begin
          if (cur_data == `CMD_SR_ENTER && is_unlock) begin
            dev_d = STATUS_READ_STATE;
            ret_d = dev_q;
          end else if (status_q[`SR_READY_BIT] && (cur_data == `CMD_RESET ||
                       (cur_data == `CMD_SR_CLEAR && is_unlock))) begin
            dev_d = ARRAY_READ;
          end
        end
        FREEZE_SET_STATE: begin
          if (cur_data == `CMD_LOCK_SET && !lr_q[`LR_FREEZE_BIT_A] &&
              !lr_q[`LR_FREEZE_BIT_B]) begin
            dev_d = LOCK_FREEZE_MODE;
          end
        end
        VOLATILE_SET_CLEAR_STATE: begin
          if (cur_data == `CMD_LOCK_SET || cur_data == `CMD_LOCK_CLEAR) begin
            dev_d = VOLATILE_SECTOR_LOCK_MODE;
          end
        end
        NV_LOCK_EXIT_PENDING, FREEZE_EXIT_PENDING, VOLATILE_EXIT_PENDING: begin
          if (cur_data == `CMD_EXIT) begin
            dev_d = ARRAY_READ;
          end
        end
        default: dev_d = dev_q;
      endcase
    end
  end

  // ****************************************************************
  // operation sequencer
  // ****************************************************************
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      M_IDLE:     st_d = start_ok ? M_SEQ : M_IDLE;
      M_SEQ: begin
        if (eng_done && seq_last) begin
          st_d = (op_q == OP_NV_PROGRAM || op_q == OP_NV_ERASE) ? M_POLL_ENT :
                 (op_q == OP_STATUS) ? M_STAT_RD : M_IDLE;
        end
      end
      M_POLL_ENT: st_d = eng_done ? M_POLL_RD : M_POLL_ENT;
      // busy polling: re-enter status read until ready, no timeout
      M_POLL_RD: begin
        if (eng_done) begin
          st_d = sr_ready ? M_CLEAR : M_POLL_ENT;
        end
      end
      M_CLEAR:    st_d = eng_done ? M_IDLE : M_CLEAR;
      M_STAT_RD:  st_d = eng_done ? M_IDLE : M_STAT_RD;
      default:    st_d = M_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_q     <= M_IDLE;
      op_q     <= OP_ABORT;
      step_q   <= 1'b0;
      issued_q <= 1'b0;
      sa_q     <= '0;
      lr_q     <= 16'h0000;
      dev_q    <= ARRAY_READ;
      ret_q    <= ARRAY_READ;
      status_q <= 16'h0000;
      done_q   <= 1'b0;
      err_q    <= 1'b0;
    end else begin
      st_q   <= st_d;
      dev_q  <= dev_d;
      ret_q  <= ret_d;
      done_q <= eng_done && (st_d == M_IDLE) && (st_q != M_IDLE);
      err_q  <= start_i && ready_o && !start_ok;
      if (start_ok) begin
        op_q   <= op_i;
        sa_q   <= sector_addr_i;
        lr_q   <= lock_config_i;
        step_q <= 1'b0;
      end else if (eng_done && st_q == M_SEQ && !seq_last) begin
        step_q <= 1'b1;
      end
      if (eng_req) begin
        issued_q <= 1'b1;
      end else if (eng_done) begin
        issued_q <= 1'b0;
      end
      if (eng_done && !cur_write) begin
        status_q <= eng_rdata;
      end
    end
  end

endmodule

// ===== verif/lock_overlay_host_sva.sv
// port checker for the lock overlay host
// assumes it is bound onto lock_overlay_host, ports connected by name
module lock_overlay_host_sva
  import lock_ctl_pkg::*;
(
  // clock, reset and request
  input wire logic        mclk_i, rstn_i, start_i, ready_o, done_o, err_o,
  input wire host_op_t    op_i,
  input wire logic [15:0] lock_config_i, status_o, dq_o,
  input wire dev_state_t  dev_state_o,
  // flash pins
  input wire logic [25:0] flash_addr_o,
  input wire logic        dq_oe_o, ce_n_o, we_n_o, oe_n_o
);
  timeunit 1ns / 1ps;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  wire go = start_i && ready_o;

  status_addr_a: assert property ($fell(we_n_o) && dq_o == 16'h0070 |->
    flash_addr_o == 26'h0000555) else $error("status entry at wrong address");
  req_entry_a: assert property (go && op_i == OP_NV_PROGRAM &&
    dev_state_o == NONVOLATILE_SECTOR_LOCK_MODE |-> ##[1:20] ($fell(we_n_o) && dq_o == 16'h00A0))
    else $error("program request word missing");
  erase_seq_a: assert property (go && op_i == OP_NV_ERASE &&
    dev_state_o == NONVOLATILE_SECTOR_LOCK_MODE |-> ##[1:20] ($fell(we_n_o) && dq_o == 16'h0080)
    ##[5:30] ($fell(we_n_o) && dq_o == 16'h0030 && flash_addr_o == 26'h0))
    else $error("erase sequence wrong");
  abort_read_a: assert property (go && op_i == OP_ABORT && dev_state_o != ARRAY_READ
    |-> ##[1:40] dev_state_o == ARRAY_READ) else $error("abort did not return to read");
  clear_ready_a: assert property ($fell(we_n_o) && dq_o == 16'h0071
    |-> status_o[7]) else $error("status cleared while busy");
  exit_seq_a: assert property (go && op_i == OP_EXIT && dev_state_o != ARRAY_READ
    |-> ##[1:20] ($fell(we_n_o) && dq_o == 16'h0090) ##[5:30] ($fell(we_n_o) && dq_o == 16'h0))
    else $error("exit sequence wrong");
  freeze_ref_a: assert property (go && op_i == OP_FREEZE &&
    (lock_config_i[2] || lock_config_i[5]) |=> err_o) else $error("freeze not refused");
  vol_clear_a: assert property (go && op_i == OP_VOL_CLEAR &&
    dev_state_o == VOLATILE_SECTOR_LOCK_MODE |-> ##[10:40] ($fell(we_n_o) && dq_o == 16'h0001))
    else $error("volatile clear word missing");
  idle_pins_a: assert property (ready_o |-> ce_n_o && we_n_o && oe_n_o && !dq_oe_o)
    else $error("bus active while idle");
  read_turn_a: assert property (!oe_n_o |-> !dq_oe_o && we_n_o)
    else $error("data bus fight during read");

  cover property (go && op_i == OP_NV_PROGRAM);
  cover property (err_o);
  cover property ($fell(we_n_o) && dq_o == 16'h0071);
endmodule

bind lock_overlay_host lock_overlay_host_sva i_lock_overlay_host_sva (.*);

// ===== verif/flash_lock_model.sv
// behavioural flash device for the lock overlay modes
// assumes synchronous pins from the host; mode entry mirrored from the bench
module flash_lock_model
  import lock_ctl_pkg::*;
#(parameter int BUSY_CYC = 50)
(
  input  wire logic        mclk_i, rstn_i, mode_enter_i,
  input  wire mode_sel_t   mode_sel_i,
  input  wire logic [15:0] lock_config_i, dq_o,
  input  wire logic [25:0] flash_addr_o,
  input  wire logic        ce_n_o, we_n_o, oe_n_o,
  output logic [15:0]      dq_i,
  output dev_state_t       state_o,
  output logic             vlock_o, freeze_o,
  output logic [1:0]       nv_op_o,
  output logic [25:0]      last_sa_o
);
  timeunit 1ns / 1ps;
  logic        we_q, oe_q, sr_pend, rd_sr;
  logic [15:0] last = 16'h0;
  int          busy;
  wire         rdy = (busy == 0);
  wire [15:0]  sr = {8'h00, rdy, 7'h00};
  wire [7:0]   c = dq_o[7:0];
  wire         at555 = flash_addr_o == 26'h0000555;
  // released bus shows the inverse, not a stale value
  assign dq_i = (!oe_n_o && !ce_n_o) ? (rd_sr ? sr : 16'h5A3C) : ~last;

  always @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_o <= ARRAY_READ; we_q <= 1'b1; oe_q <= 1'b1; sr_pend <= 1'b0; rd_sr <= 1'b0;
      busy <= 0; vlock_o <= 1'b0; freeze_o <= 1'b0; nv_op_o <= 2'h0; last_sa_o <= 26'h0;
    end else begin
      we_q <= we_n_o;
      oe_q <= oe_n_o;
      if (!oe_n_o) last <= dq_i;
      if (busy > 0) busy <= busy - 1;
      if (oe_q && !oe_n_o) begin
        rd_sr <= sr_pend;
        sr_pend <= 1'b0;
      end
      if (mode_enter_i && state_o == ARRAY_READ) begin
        case (mode_sel_i)
          ENTER_NV: state_o <= NONVOLATILE_SECTOR_LOCK_MODE;
          ENTER_FREEZE: state_o <= LOCK_FREEZE_MODE;
          default: state_o <= VOLATILE_SECTOR_LOCK_MODE;
        endcase
      end
      if (we_q && !we_n_o && !ce_n_o) begin
        if (c == 8'h70 && at555) sr_pend <= 1'b1;
        else case (state_o)
          NONVOLATILE_SECTOR_LOCK_MODE: begin
            if (c == 8'hF0) state_o <= ARRAY_READ;
            else if (c == 8'hA0 || c == 8'h80) state_o <= NV_LOCK_REQUEST_STATE;
            else if (c == 8'h90) state_o <= NV_LOCK_EXIT_PENDING;
          end
          NV_LOCK_REQUEST_STATE: begin
            if (c == 8'h00) begin
              state_o <= NV_LOCK_PROGRAM_BUSY; busy <= BUSY_CYC; nv_op_o <= 2'h1;
              last_sa_o <= flash_addr_o;
            end else if (c == 8'h30 && flash_addr_o == 26'h0) begin
              state_o <= NV_LOCK_ERASE_BUSY; busy <= BUSY_CYC; nv_op_o <= 2'h2;
            end else if (c == 8'hF0) state_o <= ARRAY_READ;
          end
          NV_LOCK_PROGRAM_BUSY, NV_LOCK_ERASE_BUSY:
            if (rdy && (c == 8'hF0 || (c == 8'h71 && at555))) state_o <= ARRAY_READ;
          LOCK_FREEZE_MODE: begin
            if (c == 8'hF0) state_o <= ARRAY_READ;
            else if (c == 8'hA0) state_o <= FREEZE_SET_STATE;
            else if (c == 8'h90) state_o <= FREEZE_EXIT_PENDING;
          end
          FREEZE_SET_STATE: if (c == 8'h00) begin
            state_o <= LOCK_FREEZE_MODE;
            if (!lock_config_i[2] && !lock_config_i[5]) freeze_o <= 1'b1;
          end
          VOLATILE_SECTOR_LOCK_MODE: begin
            if (c == 8'hF0) state_o <= ARRAY_READ;
            else if (c == 8'hA0) state_o <= VOLATILE_SET_CLEAR_STATE;
            else if (c == 8'h90) state_o <= VOLATILE_EXIT_PENDING;
          end
          VOLATILE_SET_CLEAR_STATE: if (c == 8'h00 || c == 8'h01) begin
            vlock_o <= (c == 8'h00); last_sa_o <= flash_addr_o;
            state_o <= VOLATILE_SECTOR_LOCK_MODE;
          end
          NV_LOCK_EXIT_PENDING, FREEZE_EXIT_PENDING, VOLATILE_EXIT_PENDING:
            if (c == 8'h00) state_o <= ARRAY_READ;
          default: ;
        endcase
      end
    end
  end
endmodule

// ===== verif/test_lock_overlay_host.sv
// self-checking bench for the lock overlay host
// assumes the flash_lock_model device and the bound port checker
module test_lock_overlay_host;
  timeunit 1ns / 1ps;
  import lock_ctl_pkg::*;
  logic mclk = 0, rstn = 0, menter = 0, start = 0;
  mode_sel_t msel = ENTER_NV;
  host_op_t op = OP_ABORT;
  logic [15:0] cfg = 16'h0, status, dqo, dqi;
  logic [25:0] sa = 26'h0, addr, lsa;
  logic ready, done, err, dqoe, cen, wen, oen, vlock, frz;
  logic [1:0] nvop;
  dev_state_t dstate, mst;
  int mismatches = 0, n_compared = 0;
  always #5 mclk = ~mclk;

  lock_overlay_host i_lock_overlay_host (.mclk_i(mclk), .rstn_i(rstn), .mode_enter_i(menter),
    .mode_sel_i(msel), .lock_config_i(cfg), .start_i(start), .op_i(op), .sector_addr_i(sa),
    .ready_o(ready), .done_o(done), .err_o(err), .status_o(status), .dev_state_o(dstate),
    .flash_addr_o(addr), .dq_o(dqo), .dq_oe_o(dqoe), .dq_i(dqi), .ce_n_o(cen), .we_n_o(wen),
    .oe_n_o(oen));
  flash_lock_model i_flash_lock_model (.mclk_i(mclk), .rstn_i(rstn), .mode_enter_i(menter),
    .mode_sel_i(msel), .lock_config_i(cfg), .dq_o(dqo), .flash_addr_o(addr), .ce_n_o(cen),
    .we_n_o(wen), .oe_n_o(oen), .dq_i(dqi), .state_o(mst), .vlock_o(vlock), .freeze_o(frz),
    .nv_op_o(nvop), .last_sa_o(lsa));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic conclude;
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // one operation; waits for done or refusal, bounded
  task automatic run(input host_op_t o, input logic [25:0] a, input logic exp_err);
    int n;
    @(posedge mclk);
    start <= 1'b1; op <= o; sa <= a;
    @(posedge mclk);
    start <= 1'b0;
    for (n = 0; n < 3000 && done !== 1'b1 && err !== 1'b1; n++) @(negedge mclk);
    if (n == 3000) begin
      chk(1'b0, 1'b1);
      conclude();
    end
    chk(err, exp_err);
  endtask

  task automatic enter(input mode_sel_t m, input dev_state_t s);
    @(posedge mclk);
    menter <= 1'b1; msel <= m;
    @(posedge mclk);
    menter <= 1'b0;
    @(negedge mclk);
    chk(dstate, s);
  endtask

  task automatic t_refuse;
    run(OP_NV_PROGRAM, 26'h0040000, 1'b1);
    chk({nvop, dstate}, {2'h0, ARRAY_READ});
    $display("refusal test done");
  endtask

  task automatic t_nv;
    enter(ENTER_NV, NONVOLATILE_SECTOR_LOCK_MODE);
    run(OP_NV_PROGRAM, 26'h0120000, 1'b0);
    chk({nvop, lsa}, {2'h1, 26'h0120000});
    chk({status, dstate, mst}, {16'h0080, ARRAY_READ, ARRAY_READ});
    enter(ENTER_NV, NONVOLATILE_SECTOR_LOCK_MODE);
    run(OP_NV_ERASE, 26'h0, 1'b0);
    chk({nvop, dstate, mst}, {2'h2, ARRAY_READ, ARRAY_READ});
    enter(ENTER_NV, NONVOLATILE_SECTOR_LOCK_MODE);
    run(OP_STATUS, 26'h0, 1'b0);
    chk({status, mst}, {16'h0080, NONVOLATILE_SECTOR_LOCK_MODE});
    run(OP_EXIT, 26'h0, 1'b0);
    chk({dstate, mst}, {ARRAY_READ, ARRAY_READ});
    enter(ENTER_NV, NONVOLATILE_SECTOR_LOCK_MODE);
    run(OP_ABORT, 26'h0, 1'b0);
    chk({dstate, mst}, {ARRAY_READ, ARRAY_READ});
    $display("nonvolatile test done");
  endtask

  task automatic t_freeze;
    enter(ENTER_FREEZE, LOCK_FREEZE_MODE);
    @(posedge mclk) cfg <= 16'h0020;
    run(OP_FREEZE, 26'h0, 1'b1);
    @(posedge mclk) cfg <= 16'h0004;
    run(OP_FREEZE, 26'h0, 1'b1);
    chk(frz, 1'b0);
    @(posedge mclk) cfg <= 16'h0000;
    run(OP_FREEZE, 26'h0, 1'b0);
    chk({frz, dstate, mst}, {1'b1, LOCK_FREEZE_MODE, LOCK_FREEZE_MODE});
    run(OP_STATUS, 26'h0, 1'b0);
    chk(mst, LOCK_FREEZE_MODE);
    run(OP_EXIT, 26'h0, 1'b0);
    chk({dstate, mst}, {ARRAY_READ, ARRAY_READ});
    $display("freeze test done");
  endtask

  task automatic t_vol;
    enter(ENTER_VOLATILE, VOLATILE_SECTOR_LOCK_MODE);
    run(OP_VOL_SET, 26'h03E0000, 1'b0);
    chk({vlock, lsa, mst}, {1'b1, 26'h03E0000, VOLATILE_SECTOR_LOCK_MODE});
    run(OP_VOL_CLEAR, 26'h03E0000, 1'b0);
    chk({vlock, dstate}, {1'b0, VOLATILE_SECTOR_LOCK_MODE});
    run(OP_ABORT, 26'h0, 1'b0);
    chk(mst, ARRAY_READ);
    enter(ENTER_VOLATILE, VOLATILE_SECTOR_LOCK_MODE);
    run(OP_EXIT, 26'h0, 1'b0);
    chk({dstate, mst}, {ARRAY_READ, ARRAY_READ});
    $display("volatile test done");
  endtask

  initial begin
    repeat (16) @(posedge mclk);
    rstn <= 1'b1;
    @(negedge mclk);
    chk({ready, done, err, cen, wen, oen, dqoe, status}, {7'b1001110, 16'h0});
    t_refuse();
    t_nv();
    t_freeze();
    t_vol();
    conclude();
  end
endmodule
